// File: core/mrc_regs.sv
// Rms results, rms offsets, power trims, energy divider and read checksum
//
// Summary of operation
// - Six 24-bit read-only rms results, three current and three voltage; source picked by mode bits outside.
// - Twelve-bit active power trims scale each phase by +-50 percent, 0.0244 percent steps.
// - Voltage level trims scale each phase's apparent power likewise, +-50 percent.
// - Eight-bit read-only count of one bits in the last value read.
// - Six twelve-bit read/write rms offset registers, resetting to zero.
// - Eight-bit read/write apparent energy divider, reset zero, driven to datapath.
// - Read/write registers take reads and writes; read-only ones only answer reads.
`timescale 1ns/10ps
module mrc_regs #(
  // Die revision value is arbitrary
  parameter logic [7:0] DIE_REV = 8'h5a
) (
  input  wire logic              clk_in,
  input  wire logic              rst_b_in,
  input  wire mrc_pkg::mrc_req_t req_in,
  output logic              [23:0] rd_data_out,
  output logic                     rd_valid_out,
  input  wire logic              rms_update_in,
  input  wire mrc_pkg::mrc_rms_t rms_in,
  input  wire mrc_pkg::mrc_pwr_t active_power_in,
  input  wire mrc_pkg::mrc_pwr_t apparent_power_in,
  output mrc_pkg::mrc_pwr_t      active_power_out,
  output mrc_pkg::mrc_pwr_t      apparent_power_out,
  output mrc_pkg::mrc_ofs_t      rms_offset_out,
  output logic              [7:0]  energy_divider_out
);

  ////////////////////////////////////////////////////////////////////////////////
  // Decode helpers

  function automatic logic is_cal(input logic [5:0] a);
    return (a >= mrc_pkg::ADDR_IA_RMS_OFS) && (a <= mrc_pkg::ADDR_C_VL_TRIM);
  endfunction

  function automatic logic is_rms(input logic [5:0] a);
    return (a >= mrc_pkg::ADDR_IA_RMS) && (a <= mrc_pkg::ADDR_VC_RMS);
  endfunction

  function automatic logic [7:0] ones_of(input logic [23:0] v);
    logic [7:0] n;
    n = 8'h00;
    for (int k = 0; k < mrc_pkg::DATA_W; k++) begin
      n = n + 8'(v[k]);
    end
    return n;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Storage

  logic [7:0]  divider_reg;
  logic [11:0] cal_reg [mrc_pkg::CAL_REGS];
  logic [23:0] rms_reg [mrc_pkg::RMS_CH];
  logic [7:0]  ones_reg;
  logic [7:0]  ones_next;
  logic [23:0] rd_data_next;
  logic        wr_ok;

  // Only writable offsets are honoured; all others fall through untouched
  assign wr_ok = req_in.wr &&
                 ((req_in.addr == mrc_pkg::ADDR_VA_DIV) || is_cal(req_in.addr));

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      divider_reg <= mrc_pkg::RST_DIV;
    end else if (req_in.wr && req_in.addr == mrc_pkg::ADDR_VA_DIV) begin
      divider_reg <= req_in.wdata[7:0];
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < mrc_pkg::CAL_REGS; gi++) begin : g_cal
      always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
          cal_reg[gi] <= mrc_pkg::RST_CAL;
        end else if (req_in.wr && is_cal(req_in.addr) &&
                     req_in.addr == 6'(mrc_pkg::ADDR_IA_RMS_OFS + gi)) begin
          cal_reg[gi] <= req_in.wdata[11:0];
        end
      end
    end

    // Results come only from the datapath, never from a host write
    for (gi = 0; gi < mrc_pkg::RMS_CH; gi++) begin : g_rms
      always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
          rms_reg[gi] <= mrc_pkg::RST_RMS;
        end else if (rms_update_in) begin
          rms_reg[gi] <= rms_in[gi];
        end
      end
      assign rms_offset_out[gi] = cal_reg[mrc_pkg::CAL_OFS_BASE + gi];
    end

    for (gi = 0; gi < mrc_pkg::PHASES; gi++) begin : g_scale
      mrc_gain_scale u_active (
        .clk_in    (clk_in),
        .rst_b_in  (rst_b_in),
        .power_in  (active_power_in[gi]),
        .trim_in   (cal_reg[mrc_pkg::CAL_AP_BASE + gi]),
        .power_out (active_power_out[gi])
      );
      mrc_gain_scale u_apparent (
        .clk_in    (clk_in),
        .rst_b_in  (rst_b_in),
        .power_in  (apparent_power_in[gi]),
        .trim_in   (cal_reg[mrc_pkg::CAL_VL_BASE + gi]),
        .power_out (apparent_power_out[gi])
      );
    end
  endgenerate

  assign energy_divider_out = divider_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // Read path

  always_comb begin
    rd_data_next = mrc_pkg::RD_ZERO;
    if (req_in.addr == mrc_pkg::ADDR_VA_DIV) begin
      rd_data_next = {16'h0000, divider_reg};
    end else if (is_rms(req_in.addr)) begin
      rd_data_next = rms_reg[3'(req_in.addr - mrc_pkg::ADDR_IA_RMS)];
    end else if (is_cal(req_in.addr)) begin
      rd_data_next = {12'h000, cal_reg[4'(req_in.addr - mrc_pkg::ADDR_IA_RMS_OFS)]};
    end else if (req_in.addr == mrc_pkg::ADDR_ONES_COUNT) begin
      rd_data_next = {16'h0000, ones_reg};
    end else if (req_in.addr == mrc_pkg::ADDR_DIE_REV) begin
      rd_data_next = {16'h0000, DIE_REV};
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rd_data_out  <= mrc_pkg::RD_ZERO;
      rd_valid_out <= 1'b0;
    end else begin
      rd_valid_out <= req_in.rd;
      if (req_in.rd) begin
        rd_data_out <= rd_data_next;
      end
    end
  end

  // Counted from the returned word, so reading this register counts itself next time
  assign ones_next = ones_of(rd_data_next);

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ones_reg <= mrc_pkg::RST_ONES;
    end else if (req_in.rd) begin
      ones_reg <= ones_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_b_in);

  ////////////////////////////////////////////////////////////////////////////////
  // Sequences

  sequence s_read;
    req_in.rd && !req_in.wr;
  endsequence

  sequence s_read_done;
    ##1 rd_valid_out;
  endsequence

  sequence s_read_ones;
    req_in.rd && req_in.addr == mrc_pkg::ADDR_ONES_COUNT;
  endsequence

  sequence s_write_div;
    req_in.wr && req_in.addr == mrc_pkg::ADDR_VA_DIV;
  endsequence

  sequence s_read_div;
    req_in.rd && req_in.addr == mrc_pkg::ADDR_VA_DIV;
  endsequence

  sequence s_idle_port;
    !req_in.rd && !req_in.wr;
  endsequence

  sequence s_read_reserved;
    req_in.rd && (req_in.addr > mrc_pkg::ADDR_C_VL_TRIM) &&
    (req_in.addr < mrc_pkg::ADDR_ONES_COUNT);
  endsequence

  ////////////////////////////////////////////////////////////////////////////////
  // Properties

  read_answer_a: assert property (
    s_read |-> s_read_done ##0 (rd_data_out == $past(rd_data_next)))
    else $error("read answer wrong or late");

  ones_count_a: assert property (
    s_read_ones |-> s_read_done ##0 (rd_data_out == 24'(ones_of($past(rd_data_out)))))
    else $error("checksum not ones of last read");

  reserved_zero_a: assert property (
    (req_in.rd && !is_rms(req_in.addr) && !is_cal(req_in.addr) &&
     req_in.addr != mrc_pkg::ADDR_VA_DIV && req_in.addr != mrc_pkg::ADDR_ONES_COUNT &&
     req_in.addr != mrc_pkg::ADDR_DIE_REV) |=> (rd_data_out == mrc_pkg::RD_ZERO))
    else $error("reserved read not zero");

  divider_write_a: assert property (
    (req_in.wr && req_in.addr == mrc_pkg::ADDR_VA_DIV)
    |=> (energy_divider_out == $past(req_in.wdata[7:0])))
    else $error("divider write lost");

  divider_hold_a: assert property (
    !(req_in.wr && req_in.addr == mrc_pkg::ADDR_VA_DIV) |=> $stable(energy_divider_out))
    else $error("divider changed without write");

  offset_write_a: assert property (
    (req_in.wr && req_in.addr == mrc_pkg::ADDR_IC_RMS_OFS)
    |=> (rms_offset_out[2] == $past(req_in.wdata[11:0])))
    else $error("offset write lost");

  rms_readonly_a: assert property (
    (!rms_update_in && req_in.wr && is_rms(req_in.addr) && !wr_ok)
    |=> (rms_reg[0] == $past(rms_reg[0])))
    else $error("rms result took host write");

  rms_update_a: assert property (
    rms_update_in |=> (rms_reg[3] == $past(rms_in[3])))
    else $error("rms result not captured");

  trim_scale_a: assert property (
    (cal_reg[mrc_pkg::CAL_AP_BASE] == 12'h000) ##0 $stable(active_power_in[0])
    |=> (active_power_out[0] == $past(active_power_in[0])))
    else $error("zero trim changed power");

  level_trim_a: assert property (
    (cal_reg[mrc_pkg::CAL_VL_BASE + 1] == 12'h800) ##0
    (apparent_power_in[1] == 24'h100000)
    |=> (apparent_power_out[1] == 24'h080000))
    else $error("half trim not minus fifty percent");

  read_pulse_a: assert property (
    !req_in.rd |=> !rd_valid_out)
    else $error("read valid without read");

  valid_follow_a: assert property (
    req_in.rd |=> rd_valid_out)
    else $error("read valid missing");

  read_hold_a: assert property (
    !req_in.rd |=> $stable(rd_data_out))
    else $error("read data moved without read");

  // Holds at every edge since both move on the same read
  ones_track_a: assert property (
    ones_reg == ones_of(rd_data_out))
    else $error("checksum out of step with read data");

  ones_hold_a: assert property (
    s_idle_port |=> $stable(ones_reg))
    else $error("checksum moved without read");

  reserved_ones_a: assert property (
    s_read_reserved ##1 s_idle_port ##1 s_read_ones |=> (rd_data_out == mrc_pkg::RD_ZERO))
    else $error("checksum after reserved read not zero");

  die_rev_a: assert property (
    (req_in.rd && req_in.addr == mrc_pkg::ADDR_DIE_REV)
    |=> (rd_data_out == {16'h0000, DIE_REV}))
    else $error("die revision read wrong");

  divider_read_a: assert property (
    s_read_div |=> (rd_data_out == {16'h0000, $past(energy_divider_out)}))
    else $error("divider read wrong");

  divider_round_a: assert property (
    s_write_div ##1 s_idle_port ##1 s_read_div
    |=> (rd_data_out[7:0] == $past(req_in.wdata[7:0], 3)))
    else $error("divider write not read back");

  rms_read_a: assert property (
    (req_in.rd && req_in.addr == mrc_pkg::ADDR_IB_RMS)
    |=> (rd_data_out == $past(rms_reg[1])))
    else $error("rms result read wrong");

  cal_upper_a: assert property (
    (req_in.rd && is_cal(req_in.addr)) |=> (rd_data_out[23:12] == 12'h000))
    else $error("calibration read upper bits set");

  offset_read_a: assert property (
    (req_in.rd && req_in.addr == mrc_pkg::ADDR_VA_RMS_OFS)
    |=> (rd_data_out == {12'h000, $past(rms_offset_out[3])}))
    else $error("offset read wrong");

  trim_read_a: assert property (
    (req_in.rd && req_in.addr == mrc_pkg::ADDR_B_AP_TRIM)
    |=> (rd_data_out == {12'h000, $past(cal_reg[mrc_pkg::CAL_AP_BASE + 1])}))
    else $error("active power trim read wrong");

  level_read_a: assert property (
    (req_in.rd && req_in.addr == mrc_pkg::ADDR_A_VL_TRIM)
    |=> (rd_data_out == {12'h000, $past(cal_reg[mrc_pkg::CAL_VL_BASE])}))
    else $error("voltage level trim read wrong");

  rms_hold_a: assert property (
    !rms_update_in |=> $stable(rms_reg[5]))
    else $error("rms result moved without update");

  offset_hold_a: assert property (
    !(req_in.wr && is_cal(req_in.addr)) |=> $stable(rms_offset_out))
    else $error("offset moved without write");

  reserved_write_a: assert property (
    (req_in.wr && !wr_ok) |=> ($stable(energy_divider_out) && $stable(rms_offset_out)))
    else $error("refused write changed a register");

  trim_write_a: assert property (
    (req_in.wr && req_in.addr == mrc_pkg::ADDR_A_AP_TRIM)
    |=> (cal_reg[mrc_pkg::CAL_AP_BASE] == $past(req_in.wdata[11:0])))
    else $error("active power trim write lost");

  level_write_a: assert property (
    (req_in.wr && req_in.addr == mrc_pkg::ADDR_C_VL_TRIM)
    |=> (cal_reg[mrc_pkg::CAL_VL_BASE + 2] == $past(req_in.wdata[11:0])))
    else $error("voltage level trim write lost");

  apparent_zero_a: assert property (
    (cal_reg[mrc_pkg::CAL_VL_BASE] == 12'h000)
    |=> (apparent_power_out[0] == $past(apparent_power_in[0])))
    else $error("zero trim changed apparent power");

  active_sat_a: assert property (
    (cal_reg[mrc_pkg::CAL_AP_BASE + 2] == 12'h7ff) ##0
    (active_power_in[2] == 24'h7fffff)
    |=> (active_power_out[2] == 24'h7fffff))
    else $error("full trim did not saturate");

  // One write check per calibration slot, one capture check per result
  generate
    for (gi = 0; gi < mrc_pkg::CAL_REGS; gi++) begin : g_cal_chk
      cal_write_a: assert property (
        (req_in.wr && req_in.addr == 6'(mrc_pkg::ADDR_IA_RMS_OFS + gi))
        |=> (cal_reg[gi] == $past(req_in.wdata[11:0])))
        else $error("calibration write lost");
    end
    for (gi = 0; gi < mrc_pkg::RMS_CH; gi++) begin : g_rms_chk
      rms_capture_a: assert property (
        rms_update_in |=> (rms_reg[gi] == $past(rms_in[gi])))
        else $error("rms result not captured");
    end
  endgenerate

endmodule

// File: core/mrc_pkg.sv
// Shared constants and carrier types for the rms and calibration register bank
package mrc_pkg;

  localparam int ADDR_W   = 6;
  localparam int DATA_W   = 24;
  localparam int CAL_W    = 12;
  localparam int DIV_W    = 8;
  localparam int ONES_W   = 8;
  localparam int PHASES   = 3;
  localparam int RMS_CH   = 6;
  localparam int CAL_REGS = 12;
  // One trim step is 1/4096 of full scale, about 0.0244 percent
  localparam int GAIN_FRAC = 12;

  // Register offsets
  localparam logic [5:0] ADDR_VA_DIV     = 6'h28;
  localparam logic [5:0] ADDR_IA_RMS     = 6'h29;
  localparam logic [5:0] ADDR_IB_RMS     = 6'h2a;
  localparam logic [5:0] ADDR_IC_RMS     = 6'h2b;
  localparam logic [5:0] ADDR_VA_RMS     = 6'h2c;
  localparam logic [5:0] ADDR_VB_RMS     = 6'h2d;
  localparam logic [5:0] ADDR_VC_RMS     = 6'h2e;
  localparam logic [5:0] ADDR_IA_RMS_OFS = 6'h2f;
  localparam logic [5:0] ADDR_IB_RMS_OFS = 6'h30;
  localparam logic [5:0] ADDR_IC_RMS_OFS = 6'h31;
  localparam logic [5:0] ADDR_VA_RMS_OFS = 6'h32;
  localparam logic [5:0] ADDR_VB_RMS_OFS = 6'h33;
  localparam logic [5:0] ADDR_VC_RMS_OFS = 6'h34;
  localparam logic [5:0] ADDR_A_AP_TRIM  = 6'h35;
  localparam logic [5:0] ADDR_B_AP_TRIM  = 6'h36;
  localparam logic [5:0] ADDR_C_AP_TRIM  = 6'h37;
  localparam logic [5:0] ADDR_A_VL_TRIM  = 6'h38;
  localparam logic [5:0] ADDR_B_VL_TRIM  = 6'h39;
  localparam logic [5:0] ADDR_C_VL_TRIM  = 6'h3a;
  localparam logic [5:0] ADDR_ONES_COUNT = 6'h3e;
  localparam logic [5:0] ADDR_DIE_REV    = 6'h3f;

  // Calibration array slots
  localparam int CAL_OFS_BASE = 0;
  localparam int CAL_AP_BASE  = 6;
  localparam int CAL_VL_BASE  = 9;

  // Reset values
  localparam logic [7:0]  RST_DIV  = 8'h00;
  localparam logic [11:0] RST_CAL  = 12'h000;
  localparam logic [23:0] RST_RMS  = 24'h000000;
  localparam logic [7:0]  RST_ONES = 8'h00;
  localparam logic [23:0] RD_ZERO  = 24'h000000;

  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [5:0]  addr;
    logic [23:0] wdata;
  } mrc_req_t;

  typedef logic [5:0][23:0] mrc_rms_t;
  typedef logic [2:0][23:0] mrc_pwr_t;
  typedef logic [5:0][11:0] mrc_ofs_t;

endpackage

// File: core/mrc_gain_scale.sv
// One channel of power scaling by a signed twelve-bit trim
`timescale 1ns/10ps
module mrc_gain_scale (
  input  wire logic        clk_in,
  input  wire logic        rst_b_in,
  input  wire logic [23:0] power_in,
  input  wire logic [11:0] trim_in,
  output logic      [23:0] power_out
);

  logic signed [35:0] prod;
  logic signed [24:0] sum;
  logic signed [24:0] sat_hi;
  logic signed [24:0] sat_lo;

  // Trim of -2048..2047 steps gives -50..+50 percent
  assign prod   = $signed(power_in) * $signed(trim_in);
  assign sum    = 25'($signed(power_in)) + 25'($signed(prod[35:mrc_pkg::GAIN_FRAC]));
  assign sat_hi = 25'sh07fffff;
  assign sat_lo = -25'sh0800000;

  // Saturate instead of wrapping so a hot sample never flips sign
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      power_out <= mrc_pkg::RST_RMS;
    end else if (sum > sat_hi) begin
      power_out <= sat_hi[23:0];
    end else if (sum < sat_lo) begin
      power_out <= sat_lo[23:0];
    end else begin
      power_out <= sum[23:0];
    end
  end

endmodule

// File: verification/mrc_host_model.sv
// Host model issuing register reads and writes on the parallel port
`timescale 1ns/10ps
module mrc_host_model (
  input  wire logic         clk_in,
  input  wire logic [23:0]  rd_data_in,
  input  wire logic         rd_valid_in,
  output mrc_pkg::mrc_req_t req_out
);
  initial req_out = '0;
  // Requests change just after an edge and last one full cycle
  task automatic wr(input logic [5:0] a, input logic [23:0] d);
    @(posedge clk_in);
    req_out <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
    @(posedge clk_in);
    req_out <= '0;
  endtask
  task automatic rd(input logic [5:0] a, output logic [23:0] d, output logic v);
    @(posedge clk_in);
    req_out <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 24'h000000};
    @(posedge clk_in);
    req_out <= '0;
    #1;
    d = rd_data_in;
    v = rd_valid_in;
  endtask
endmodule

// File: verification/tb_mrc_regs.sv
// Self-checking bench for the rms and calibration register bank
`timescale 1ns/10ps
module tb_mrc_regs;
  // Revision value is arbitrary
  localparam logic [7:0] REV = 8'h3c;
  logic              clk_in = 1'b0;
  logic              rst_b_in = 1'b0;
  logic              upd = 1'b0;
  mrc_pkg::mrc_req_t req;
  mrc_pkg::mrc_rms_t rms = '0;
  mrc_pkg::mrc_pwr_t ap_i = '0;
  mrc_pkg::mrc_pwr_t va_i = '0;
  mrc_pkg::mrc_pwr_t ap_o;
  mrc_pkg::mrc_pwr_t va_o;
  mrc_pkg::mrc_ofs_t ofs;
  logic [7:0]        div;
  logic [23:0]       rdd;
  logic              rdv;
  logic [23:0]       exp_q [64];
  logic [23:0]       last = 24'h000000;
  int                fails = 0;
  int                checks_done = 0;
  int                cyc = 0;

  always #5 clk_in = ~clk_in;

  mrc_host_model host_u (.clk_in(clk_in), .rd_data_in(rdd), .rd_valid_in(rdv), .req_out(req));
  mrc_regs #(.DIE_REV(REV)) dut_u (
    .clk_in(clk_in), .rst_b_in(rst_b_in), .req_in(req), .rd_data_out(rdd),
    .rd_valid_out(rdv), .rms_update_in(upd), .rms_in(rms), .active_power_in(ap_i),
    .apparent_power_in(va_i), .active_power_out(ap_o), .apparent_power_out(va_o),
    .rms_offset_out(ofs), .energy_divider_out(div));

  ////////////////////////////////////////////////////////////////////////////
  task automatic results();
    if (fails == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic cmp(input string n, input logic [23:0] e, input logic [23:0] s);
    checks_done++;
    if (s !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  // Writable bits of each address; zero marks read-only or reserved
  function automatic logic [23:0] msk(input logic [5:0] a);
    if (a == 6'h28) return 24'h0000ff;
    if (a >= 6'h2f && a <= 6'h3a) return 24'h000fff;
    return 24'h000000;
  endfunction
  function automatic logic [23:0] scl(input logic [23:0] p, input logic [11:0] t);
    longint x;
    x = longint'($signed(p));
    x = x + ((x * longint'($signed(t))) >>> 12);
    if (x > 8388607) x = 8388607;
    if (x < -8388608) x = -8388608;
    return x[23:0];
  endfunction
  task automatic chk_rd(input logic [5:0] a);
    logic [23:0] d;
    logic        v;
    logic [23:0] e;
    e = (a == 6'h3e) ? 24'($countones(last)) : exp_q[a];
    host_u.rd(a, d, v);
    cmp("rd_valid", 24'h000001, {23'h000000, v});
    cmp($sformatf("reg %h", a), e, d);
    last = e;
  endtask
  task automatic wr_m(input logic [5:0] a, input logic [23:0] d);
    host_u.wr(a, d);
    if (msk(a) != 24'h000000) exp_q[a] = d & msk(a);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      results();
    end
  end

  initial begin
    void'($urandom(32'hd5e88e0d));
    foreach (exp_q[i]) exp_q[i] = 24'h000000;
    exp_q[6'h3f] = {16'h0000, REV};
    repeat (3) @(posedge clk_in);
    rst_b_in <= 1'b1;
    for (int a = 32; a < 64; a++) chk_rd(6'(a));
    for (int a = 32; a < 64; a++) wr_m(6'(a), 24'($urandom()));
    for (int a = 32; a < 64; a++) chk_rd(6'(a));
    @(posedge clk_in);
    foreach (rms[i]) rms[i] <= 24'($urandom());
    upd <= 1'b1;
    @(posedge clk_in);
    upd <= 1'b0;
    for (int i = 0; i < 6; i++) exp_q[6'h29 + i] = rms[i];
    for (int i = 0; i < 7; i++) chk_rd(6'h29 + 6'(i));
    cmp("divider", exp_q[6'h28], {16'h0000, div});
    for (int i = 0; i < 6; i++) cmp("offset", exp_q[6'h2f + i], {12'h000, ofs[i]});
    @(posedge clk_in);
    foreach (ap_i[i]) ap_i[i] <= 24'($urandom());
    foreach (va_i[i]) va_i[i] <= 24'($urandom());
    repeat (2) @(posedge clk_in);
    #1;
    for (int i = 0; i < 3; i++) begin
      cmp("active", scl(ap_i[i], exp_q[6'h35 + i][11:0]), ap_o[i]);
      cmp("apparent", scl(va_i[i], exp_q[6'h38 + i][11:0]), va_o[i]);
    end
    wr_m(6'h28, 24'($urandom()));
    chk_rd(6'h28);
    wr_m(6'h37, 24'h0007ff);
    wr_m(6'h39, 24'h000800);
    @(posedge clk_in);
    ap_i[2] <= 24'h7fffff;
    va_i[1] <= 24'h100000;
    repeat (2) @(posedge clk_in);
    #1;
    cmp("saturate", 24'h7fffff, ap_o[2]);
    cmp("half trim", 24'h080000, va_o[1]);
    // Second reset in mid-run; power inputs parked at zero across the release
    @(posedge clk_in);
    ap_i <= '0;
    va_i <= '0;
    rst_b_in <= 1'b0;
    repeat (3) @(posedge clk_in);
    rst_b_in <= 1'b1;
    foreach (exp_q[i]) exp_q[i] = 24'h000000;
    exp_q[6'h3f] = {16'h0000, REV};
    last = 24'h000000;
    for (int a = 40; a < 64; a++) chk_rd(6'(a));
    cmp("divider", 24'h000000, {16'h0000, div});
    @(posedge clk_in);
    foreach (ap_i[i]) ap_i[i] <= 24'($urandom());
    foreach (va_i[i]) va_i[i] <= 24'($urandom());
    repeat (2) @(posedge clk_in);
    #1;
    for (int i = 0; i < 3; i++) begin
      cmp("active", scl(ap_i[i], 12'h000), ap_o[i]);
      cmp("apparent", scl(va_i[i], 12'h000), va_o[i]);
    end
    results();
  end
endmodule
